// [src/osd_params.svh]
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH
// Register byte offsets
`define OSD_A_CTRL      6'h00
`define OSD_A_TXT_NRM   6'h04
`define OSD_A_TXT_FLS   6'h08
`define OSD_A_BOX       6'h0C
`define OSD_A_SCRCOL    6'h10
`define OSD_A_SCR_RANGE 6'h14
`define OSD_A_SCR_AREA  6'h18
`define OSD_A_SCR_TOP   6'h1C
`define OSD_A_STATUS    6'h20
`define OSD_A_MAP       6'h24
`define OSD_A_MAPDAT    6'h28
// Timing in ns and derived cycles at 50 MHz
`define OSD_CLK_NS      20
`define OSD_SC_START_NS 10500
`define OSD_SC_END_NS   62500
`define OSD_SC_START_CY ((`OSD_SC_START_NS + `OSD_CLK_NS - 1) / `OSD_CLK_NS)
`define OSD_SC_END_CY   (`OSD_SC_END_NS / `OSD_CLK_NS)
// Vertical screen colour ranges
`define OSD_L625_FIRST  10'h017
`define OSD_L625_LAST   10'h136
`define OSD_L525_FIRST  10'h011
`define OSD_L525_LAST   10'h104
// Display map fields
`define OSD_MAP_EN_BIT  11
`define OSD_MAP_PTR_W   10
`define OSD_MEM_BASE    16'h8000
`define OSD_TXT_ROWS    5'h19
`define OSD_TXT_COLS    6'h28
`define OSD_TXT_CTRLROW 5'h19
`endif

// [src/osd_pkg.sv]
package osd_pkg;
  typedef enum logic [1:0] {
    OSD_VIDEO = 2'b00,
    OSD_FULL  = 2'b01,
    OSD_MIXSC = 2'b10,
    OSD_MIXVD = 2'b11
  } osd_mode_type;

  typedef struct packed {
    logic       fg;
    logic       bg;
    logic       boxed;
    logic [3:0] fg_col;
    logic [3:0] bg_col;
  } osd_pix_type;

  typedef struct packed {
    logic [3:0] index;
    logic       video_sel;
  } osd_out_type;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] height;
    logic [3:0] first_row;
    logic [3:0] last_row;
    logic [3:0] top_line;
    logic [3:0] first_scroll_row;
    logic       enable;
  } osd_scroll_type;
endpackage : osd_pkg

// [src/osd_display_mode_scroll.sv]
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Mode 00 gives black and video pass
// - Mode 01 screen colour, box ignored
// - Mode 10 screen colour outside fg/box/bg
// - Mode 11 video outside fg/box/bg
// - Flash or subtitle flag selects alternate bits
// - Separate inside/outside box bit sets
// - Picture/text/background enables decode display
// - Screen colour window in time and lines
// - Caption screen colour from control register
// - Teletext screen colour zero is transparent
// - Area B uses its own teletext screen colour
// - Sixteen map words give row pointers
// - Map bit 11 enables non-scroll text
// - Scroll active only when enabled
// - Window position/height and row range fields
// - Top line and first row drive scroll; top line is only latched and output, first row alone sets the map row
// - Scroll settings latch at field sync
// - Only whole rows show at window edges
// - Teletext 25x40 grid, row 25 hidden
`include "osd_params.svh"
module osd_display_mode_scroll (
  input  wire logic               ref_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic [31:0]        wb_adr_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic [31:0]             wb_dat_out,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic               wb_we_in,
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  output logic                    wb_ack_out,
  input  wire logic               hsync_in,
  input  wire logic               vsync_in,
  input  wire logic               field_sync_in,
  input  wire logic               newsflash_flag_in,
  input  wire logic               subtitle_flag_in,
  input  wire logic               area_b_in,
  input  wire logic [4:0]         txt_row_in,
  input  wire logic [5:0]         txt_col_in,
  input  wire logic [3:0]         disp_row_in,
  input  wire osd_pkg::osd_pix_type pix_in,
  output osd_pkg::osd_out_type    rgb_out,
  output logic                    video_overlay_switch_out,
  output logic [15:0]             row_addr_out,
  output logic                    row_text_en_out,
  output logic                    in_scroll_out,
  output osd_pkg::osd_scroll_type scroll_live_out
);
  import osd_pkg::*;

  logic [2:0]     hs_sync_ff;
  logic [2:0]     vs_sync_ff;
  logic [2:0]     fs_sync_ff;
  logic           hs_state_ff;
  logic           vs_state_ff;
  logic           fs_state_ff;
  logic [11:0]    hcnt_ff;
  logic [9:0]     line_ff;
  logic [2:0]     box_half;
  logic           is525_ff;
  logic [4:0]     ctrl_ff;
  logic [7:0]     txt_nrm_ff;
  logic [7:0]     txt_fls_ff;
  logic [5:0]     box_ff;
  logic [5:0]     scrcol_ff;
  logic [7:0]     scr_range_ff;
  logic [7:0]     scr_area_ff;
  logic [3:0]     scr_top_ff;
  logic [4:0]     status_ff;
  logic [3:0]     map_idx_ff;
  logic [11:0]    map_ff [16];
  osd_scroll_type scroll_ff;
  osd_out_type    out_ff;
  logic           vds_ff;
  logic [15:0]    row_addr_ff;
  logic           row_en_ff;
  logic           in_scroll_ff;
  logic           ack_ff;
  logic [31:0]    rdat_ff;
  logic           hs_rise;
  logic           fs_rise;
  logic           vs_rise;
  logic           wr_req;
  logic           rd_req;
  logic [5:0]     adr;
  logic           win_h;
  logic           win_v;
  logic           win;
  logic [2:0]     txt_bits;
  logic [2:0]     tsc;
  logic           box_on;
  logic           inside_box;
  logic           txt_visible;
  logic [3:0]     srow;
  logic           in_win;
  logic [3:0]     map_row;
  osd_out_type    nxt_out;
  logic           nxt_vds;

  assign adr    = wb_adr_in[5:0];
  assign wr_req = wb_cyc_in & wb_stb_in & wb_we_in & ~ack_ff;
  assign rd_req = wb_cyc_in & wb_stb_in & ~wb_we_in & ~ack_ff;

  // Three-stage input sampling, change taken when stages two and three agree
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hs_sync_ff  <= 3'h0;
      vs_sync_ff  <= 3'h0;
      fs_sync_ff  <= 3'h0;
      hs_state_ff <= 1'b0;
      vs_state_ff <= 1'b0;
      fs_state_ff <= 1'b0;
    end else begin
      hs_sync_ff <= {hs_sync_ff[1:0], hsync_in};
      vs_sync_ff <= {vs_sync_ff[1:0], vsync_in};
      fs_sync_ff <= {fs_sync_ff[1:0], field_sync_in};
      if (hs_sync_ff[1] == hs_sync_ff[2]) begin
        hs_state_ff <= hs_sync_ff[2];
      end
      if (vs_sync_ff[1] == vs_sync_ff[2]) begin
        vs_state_ff <= vs_sync_ff[2];
      end
      if (fs_sync_ff[1] == fs_sync_ff[2]) begin
        fs_state_ff <= fs_sync_ff[2];
      end
    end
  end

  assign hs_rise = (hs_sync_ff[1] == hs_sync_ff[2]) & hs_sync_ff[2] & ~hs_state_ff;
  assign vs_rise = (vs_sync_ff[1] == vs_sync_ff[2]) & vs_sync_ff[2] & ~vs_state_ff;
  assign fs_rise = (fs_sync_ff[1] == fs_sync_ff[2]) & fs_sync_ff[2] & ~fs_state_ff;

  // Line timing and line counting
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hcnt_ff       <= 12'h000;
      line_ff       <= 10'h000;
      is525_ff      <= 1'b0;
    end else begin
      if (hs_rise) begin
        hcnt_ff <= 12'h000;
      end else if (hcnt_ff != 12'hFFF) begin
        hcnt_ff <= hcnt_ff + 12'h001;
      end
      if (vs_rise) begin
        line_ff       <= 10'h001;
        is525_ff      <= (line_ff < 10'h11D);
      end else if (hs_rise && line_ff != 10'h3FF) begin
        line_ff <= line_ff + 10'h001;
      end
    end
  end

  assign win_h = (hcnt_ff >= 12'(`OSD_SC_START_CY)) && (hcnt_ff < 12'(`OSD_SC_END_CY));
  assign win_v = is525_ff ? (line_ff >= `OSD_L525_FIRST && line_ff <= `OSD_L525_LAST)
                          : (line_ff >= `OSD_L625_FIRST && line_ff <= `OSD_L625_LAST);
  assign win   = win_h & win_v;

  // Register writes
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl_ff      <= 5'h00;
      txt_nrm_ff   <= 8'h00;
      txt_fls_ff   <= 8'h00;
      box_ff       <= 6'h00;
      scrcol_ff    <= 6'h00;
      scr_range_ff <= 8'h00;
      scr_area_ff  <= 8'h00;
      scr_top_ff   <= 4'h0;
      status_ff    <= 5'h00;
      map_idx_ff   <= 4'h0;
    end else if (wr_req && wb_sel_in[0]) begin
      case (adr)
        `OSD_A_CTRL:      ctrl_ff      <= wb_dat_in[4:0];
        `OSD_A_TXT_NRM:   txt_nrm_ff   <= wb_dat_in[7:0];
        `OSD_A_TXT_FLS:   txt_fls_ff   <= wb_dat_in[7:0];
        `OSD_A_BOX:       box_ff       <= wb_dat_in[5:0];
        `OSD_A_SCRCOL:    scrcol_ff    <= wb_dat_in[5:0];
        // writes accepted anywhere in the field
        `OSD_A_SCR_RANGE: scr_range_ff <= wb_dat_in[7:0];
        `OSD_A_SCR_AREA:  scr_area_ff  <= wb_dat_in[7:0];
        `OSD_A_SCR_TOP:   scr_top_ff   <= wb_dat_in[3:0];
        `OSD_A_STATUS:    status_ff    <= wb_dat_in[4:0];
        `OSD_A_MAP:       map_idx_ff   <= wb_dat_in[3:0];
        default: begin
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_map
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          map_ff[gi] <= 12'h000;
        end else if (wr_req && adr == `OSD_A_MAPDAT && map_idx_ff == 4'(gi)) begin
          if (wb_sel_in[0]) begin
            map_ff[gi][7:0] <= wb_dat_in[7:0];
          end
          if (wb_sel_in[1]) begin
            // reserved bit 10 kept at zero
            map_ff[gi][11:8] <= {wb_dat_in[11], 1'b0, wb_dat_in[9:8]};
          end
        end
      end
    end
  endgenerate

  // latch scroll settings at field sync
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      scroll_ff <= '0;
    end else if (fs_rise) begin
      scroll_ff.pos              <= scr_range_ff[7:4];
      scroll_ff.height           <= scr_range_ff[3:0];
      scroll_ff.first_row        <= scr_area_ff[7:4];
      scroll_ff.last_row         <= scr_area_ff[3:0];
      // top line and first scroll row
      scroll_ff.top_line         <= scr_top_ff;
      scroll_ff.first_scroll_row <= status_ff[3:0];
      scroll_ff.enable           <= status_ff[4];
    end
  end

  // window hit only when enabled; whole display rows only, top line offset not applied
  assign in_win = scroll_ff.enable && (disp_row_in >= scroll_ff.pos) &&
                  ({1'b0, disp_row_in} < {1'b0, scroll_ff.pos} + {1'b0, scroll_ff.height});
  // row within window starts at first scroll row
  assign srow   = 4'(scroll_ff.first_scroll_row + (disp_row_in - scroll_ff.pos));
  assign map_row = in_win ? srow : disp_row_in;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      row_addr_ff  <= 16'h0000;
      row_en_ff    <= 1'b0;
      in_scroll_ff <= 1'b0;
    end else begin
      row_addr_ff  <= `OSD_MEM_BASE + {6'h00, map_ff[map_row][`OSD_MAP_PTR_W-1:0]};
      // bit 11 gates text outside scroll area
      row_en_ff    <= in_win | map_ff[map_row][`OSD_MAP_EN_BIT];
      in_scroll_ff <= in_win;
    end
  end

  // flash or subtitle page picks alternate set; inside/outside box halves
  assign box_half   = area_b_in ? box_ff[5:3] : box_ff[2:0];
  assign box_on     = (txt_row_in == 5'h00) ? box_half[0]
                    : (txt_row_in == 5'h18) ? box_half[2]
                    : box_half[1];
  assign inside_box = pix_in.boxed & box_on;
  always_comb begin
    txt_bits = (newsflash_flag_in | subtitle_flag_in) ? txt_fls_ff[2:0] : txt_nrm_ff[2:0];
    if (inside_box) begin
      txt_bits = (newsflash_flag_in | subtitle_flag_in) ? txt_fls_ff[6:4] : txt_nrm_ff[6:4];
    end
  end
  assign tsc = area_b_in ? scrcol_ff[5:3] : scrcol_ff[2:0];
  // only rows 0..24 and columns 0..39 shown
  assign txt_visible = (txt_row_in < `OSD_TXT_ROWS) && (txt_col_in < `OSD_TXT_COLS);

  // Pixel composition
  always_comb begin
    nxt_out = '0;
    nxt_vds = 1'b0;
    if (!ctrl_ff[4]) begin
      case (osd_mode_type'(ctrl_ff[1:0]))
        OSD_VIDEO: begin
          nxt_out = '0;
          nxt_vds = 1'b0;
        end
        // full text, box ignored; screen colour index from control
        OSD_FULL: begin
          nxt_vds = 1'b1;
          if (pix_in.fg) nxt_out.index = pix_in.fg_col;
          else if (pix_in.bg) nxt_out.index = pix_in.bg_col;
          else if (win) nxt_out.index = {ctrl_ff[3:2], 2'b00};
        end
        // screen colour outside fg, box and bg
        OSD_MIXSC: begin
          nxt_vds = 1'b1;
          if (pix_in.fg) nxt_out.index = pix_in.fg_col;
          else if (pix_in.bg || pix_in.boxed) nxt_out.index = pix_in.bg_col;
          else if (win) nxt_out.index = {ctrl_ff[3:2], 2'b00};
          else nxt_vds = 1'b0;
        end
        // video outside fg, box and bg
        OSD_MIXVD: begin
          nxt_vds = pix_in.fg | pix_in.bg | pix_in.boxed;
          if (pix_in.fg) nxt_out.index = pix_in.fg_col;
          else if (pix_in.bg || pix_in.boxed) nxt_out.index = pix_in.bg_col;
        end
        default: begin
          nxt_out = '0;
        end
      endcase
    end else begin
      case (txt_bits)
        3'b000, 3'b001: nxt_vds = 1'b1;
        3'b010: begin
          nxt_vds = 1'b1;
          if (txt_visible && pix_in.fg) nxt_out.index = pix_in.fg_col;
        end
        3'b011: begin
          nxt_vds = 1'b1;
          if (txt_visible && pix_in.fg) nxt_out.index = pix_in.fg_col;
          else if (txt_visible && pix_in.bg) nxt_out.index = pix_in.bg_col;
        end
        3'b100, 3'b101: nxt_vds = 1'b0;
        3'b110: begin
          nxt_vds = txt_visible & pix_in.fg;
          if (nxt_vds) nxt_out.index = pix_in.fg_col;
        end
        3'b111: begin
          nxt_vds = txt_visible & (pix_in.fg | pix_in.bg);
          if (nxt_vds) nxt_out.index = pix_in.fg ? pix_in.fg_col : pix_in.bg_col;
        end
        default: nxt_vds = 1'b0;
      endcase
      // nonzero colour replaces picture and black background
      if (tsc != 3'h0 && win && !(txt_visible && pix_in.fg) &&
          (!nxt_vds || nxt_out.index == 4'h0)) begin
        nxt_out.index = 4'h8 + {1'b0, tsc};
        nxt_vds       = 1'b1;
      end
    end
    nxt_out.video_sel = ~nxt_vds;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      out_ff <= '0;
      vds_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      vds_ff <= nxt_vds;
    end
  end

  // Wishbone read data and acknowledge
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wr_req | rd_req;
      if (rd_req) begin
        case (adr)
          `OSD_A_CTRL:      rdat_ff <= {27'h0, ctrl_ff};
          `OSD_A_TXT_NRM:   rdat_ff <= {24'h0, txt_nrm_ff};
          `OSD_A_TXT_FLS:   rdat_ff <= {24'h0, txt_fls_ff};
          `OSD_A_BOX:       rdat_ff <= {26'h0, box_ff};
          `OSD_A_SCRCOL:    rdat_ff <= {26'h0, scrcol_ff};
          `OSD_A_SCR_RANGE: rdat_ff <= {24'h0, scr_range_ff};
          `OSD_A_SCR_AREA:  rdat_ff <= {24'h0, scr_area_ff};
          `OSD_A_SCR_TOP:   rdat_ff <= {28'h0, scr_top_ff};
          `OSD_A_STATUS:    rdat_ff <= {22'h0, is525_ff, in_scroll_ff, scroll_ff.enable,
                                        2'h0, status_ff};
          `OSD_A_MAP:       rdat_ff <= {28'h0, map_idx_ff};
          `OSD_A_MAPDAT:    rdat_ff <= {20'h0, map_ff[map_idx_ff]};
          default:          rdat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_out               = ack_ff;
  assign wb_dat_out               = rdat_ff;
  assign rgb_out                  = out_ff;
  assign video_overlay_switch_out = vds_ff;
  assign row_addr_out             = row_addr_ff;
  assign row_text_en_out          = row_en_ff;
  assign in_scroll_out            = in_scroll_ff;
  assign scroll_live_out          = scroll_ff;
endmodule : osd_display_mode_scroll

// [bench/osd_dms_asserts.sv]
`timescale 1ns/1ps
module osd_dms_chk (
  input wire logic                    ref_clk_in,
  input wire logic                    sys_rst_in,
  input wire logic                    wb_cyc_in,
  input wire logic                    wb_stb_in,
  input wire logic                    wb_we_in,
  input wire logic                    wb_ack_out,
  input wire logic                    field_sync_in,
  input wire osd_pkg::osd_out_type    rgb_out,
  input wire logic                    video_overlay_switch_out,
  input wire logic [15:0]             row_addr_out,
  input wire logic                    in_scroll_out,
  input wire osd_pkg::osd_scroll_type scroll_live_out
);
  import osd_pkg::*;
  logic       fs_q_ff;
  logic [3:0] fs_age_ff;
  logic [1:0] rst_q_ff;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Age of the last field sync rise, and reset history
  always_ff @(posedge ref_clk_in) begin
    fs_q_ff  <= field_sync_in;
    rst_q_ff <= {rst_q_ff[0], sys_rst_in};
    if (sys_rst_in)
      fs_age_ff <= 4'hF;
    else if (field_sync_in && !fs_q_ff)
      fs_age_ff <= 4'h0;
    else if (fs_age_ff != 4'hF)
      fs_age_ff <= fs_age_ff + 4'h1;
  end
  a_ack_single:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_answer:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_quiet:
    assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_vds_inverse:
    assert property (rst_q_ff == 2'b00 |-> video_overlay_switch_out != rgb_out.video_sel)
    else $error("overlay switch and video select agree");
  a_video_black:
    assert property (rgb_out.video_sel |-> rgb_out.index == 4'h0)
    else $error("video passed with colour index");
  a_row_base:
    assert property (rst_q_ff == 2'b00 |-> row_addr_out[15:10] == 6'h20)
    else $error("row address outside display memory");
  a_live_fsync:
    assert property (!$past(sys_rst_in) && $changed(scroll_live_out) |-> fs_age_ff <= 4'h8)
    else $error("scroll settings changed without field sync");
  a_scroll_off:
    assert property (!scroll_live_out.enable ##1 !scroll_live_out.enable |-> !in_scroll_out)
    else $error("scroll row while scroll disabled");
  a_reset_zero:
    assert property (@(posedge ref_clk_in) disable iff (1'b0) sys_rst_in |=>
      wb_ack_out == 1'b0 && rgb_out == '0 && row_addr_out == 16'h0 && scroll_live_out == '0)
    else $error("output not cleared by reset");
  c_write: cover property (wb_ack_out && wb_we_in);
  c_scroll: cover property (in_scroll_out);
  c_overlay: cover property ($rose(video_overlay_switch_out));
endmodule : osd_dms_chk

bind osd_display_mode_scroll osd_dms_chk u_chk (
  .ref_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_ack_out, .field_sync_in,
  .rgb_out, .video_overlay_switch_out, .row_addr_out, .in_scroll_out, .scroll_live_out
);

// [bench/osd_video_sink.sv]
`timescale 1ns/1ps
module osd_video_sink (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [2:0] req_in,
  output logic            hsync_out,
  output logic            vsync_out,
  output logic            field_sync_out
);
  logic [2:0] cnt_ff [3];
  // Sync pulses on request, each long enough to pass the input flops
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (sys_rst_in)
        cnt_ff[i] <= 3'h0;
      else if (req_in[i])
        cnt_ff[i] <= 3'h4;
      else if (cnt_ff[i] != 3'h0)
        cnt_ff[i] <= cnt_ff[i] - 3'h1;
    end
  end
  assign field_sync_out = (cnt_ff[0] != 3'h0);
  assign vsync_out      = (cnt_ff[1] != 3'h0);
  assign hsync_out      = (cnt_ff[2] != 3'h0);
endmodule : osd_video_sink

// [bench/tb_osd_display_mode_scroll.sv]
`timescale 1ns/1ps
module tb_osd_display_mode_scroll;
  import osd_pkg::*;
  logic           ref_clk_in = 1'b0;
  logic           sys_rst_in = 1'b1;
  logic [31:0]    wb_adr_in = 32'h0;
  logic [31:0]    wb_dat_in = 32'h0;
  logic [3:0]     wb_sel_in = 4'hF;
  logic           wb_we_in = 1'b0;
  logic           wb_cyc_in = 1'b0;
  logic           wb_stb_in = 1'b0;
  logic [2:0]     sync_req = 3'h0;
  logic           newsflash_flag_in = 1'b0;
  logic           subtitle_flag_in = 1'b0;
  logic           area_b_in = 1'b0;
  logic [4:0]     txt_row_in = 5'h0;
  logic [5:0]     txt_col_in = 6'h0;
  logic [3:0]     disp_row_in = 4'h0;
  osd_pix_type    pix_in = '0;
  logic [31:0]    wb_dat_out;
  logic           wb_ack_out, hsync_in, vsync_in, field_sync_in;
  logic           video_overlay_switch_out, row_text_en_out, in_scroll_out;
  logic [15:0]    row_addr_out;
  osd_out_type    rgb_out;
  osd_scroll_type scroll_live_out;
  logic [11:0]    map_w [16];
  int             errors = 0;
  int             n_tests = 0;
  int             cycles = 0;
  int             seed = 28;

  always #10 ref_clk_in = ~ref_clk_in;

  osd_display_mode_scroll dut (
    .ref_clk_in, .sys_rst_in, .wb_adr_in, .wb_dat_in, .wb_dat_out, .wb_sel_in, .wb_we_in,
    .wb_cyc_in, .wb_stb_in, .wb_ack_out, .hsync_in, .vsync_in, .field_sync_in,
    .newsflash_flag_in, .subtitle_flag_in, .area_b_in, .txt_row_in, .txt_col_in,
    .disp_row_in, .pix_in, .rgb_out, .video_overlay_switch_out, .row_addr_out,
    .row_text_en_out, .in_scroll_out, .scroll_live_out
  );
  osd_video_sink u_sink (
    .ref_clk_in, .sys_rst_in, .req_in(sync_req), .hsync_out(hsync_in),
    .vsync_out(vsync_in), .field_sync_out(field_sync_in)
  );

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic fail(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
      fail($sformatf("%s got %h expected %h", m, got, exp));
  endtask : cmp_val

  // Expected {valid, overlay, index}; pixels not valid are skipped
  task automatic cmp_vid(input logic [5:0] e, input string m);
    if (e[5]) begin
      n_tests++;
      if ({video_overlay_switch_out, rgb_out.video_sel, rgb_out.index} !== {e[4], !e[4], e[3:0]})
        fail(m);
    end
  endtask : cmp_vid

  function automatic logic [5:0] cap_exp(input logic [1:0] m, input osd_pix_type p);
    if (m == 2'b00) return 6'h20;
    if (p.fg) return {2'b11, p.fg_col};
    if (p.bg) return {2'b11, p.bg_col};
    if (m == 2'b11 && !p.boxed) return 6'h20;
    return 6'h00;
  endfunction : cap_exp

  function automatic logic [5:0] txt_exp(input logic [2:0] b, input osd_pix_type p,
                                         input logic [4:0] r, input logic [5:0] c);
    if (b[2:1] == 2'b00) return 6'h30;
    if (b[2:1] == 2'b10) return 6'h20;
    if (p.fg && r < 5'h19 && c < 6'h28) return {2'b11, p.fg_col};
    if (!b[0]) return b[2] ? 6'h20 : 6'h30;
    return 6'h00;
  endfunction : txt_exp

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {26'h0, a};
    wb_dat_in <= d;
    @(posedge ref_clk_in);
    while (wb_ack_out !== 1'b1)
      @(posedge ref_clk_in);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic px(input osd_pix_type p, input logic [4:0] r, input logic [5:0] c,
                    input logic [1:0] f);
    @(posedge ref_clk_in);
    pix_in            <= p;
    txt_row_in        <= r;
    txt_col_in        <= c;
    newsflash_flag_in <= f[1];
    subtitle_flag_in  <= f[0];
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : px

  task automatic rowchk(input logic [3:0] r, input logic [11:0] w, input logic sc);
    @(posedge ref_clk_in);
    disp_row_in <= r;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    cmp_val({14'h0, row_addr_out, sc | row_text_en_out, in_scroll_out},
            {14'h0, 16'h8000 + {6'h0, w[9:0]}, sc | w[11], sc}, "row fetch");
  endtask : rowchk

  task automatic sync(input logic [2:0] k);
    @(posedge ref_clk_in);
    sync_req <= k;
    @(posedge ref_clk_in);
    sync_req <= 3'h0;
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : sync

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail("run timed out");
      stop_test();
    end
  end

  initial begin
    logic [31:0]    q;
    logic [31:0]    d;
    logic [4:0]     r;
    osd_pix_type    p;
    osd_scroll_type e;
    logic [4:0]     rs [3];
    logic [5:0]     cs [3];
    rs = '{5'h18, 5'h19, 5'h00};
    cs = '{6'h27, 6'h00, 6'h28};
    repeat (12) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge ref_clk_in);
    cmp_val({8'h0, video_overlay_switch_out, rgb_out, row_addr_out, in_scroll_out,
             row_text_en_out}, 32'h0, "reset outputs");
    wr(6'h3C, 32'hFFFFFFFF);
    wb(1'b0, 6'h3C, 32'h0, q);
    cmp_val(q, 32'h0, "unmapped read");
    $display("bus test done");
    for (int m = 0; m < 4; m++) begin
      wr(6'h00, {30'h0, 2'(m)});
      repeat (8) begin
        p = 11'($random(seed));
        px(p, 5'h0, 6'h0, 2'b00);
        cmp_vid(cap_exp(2'(m), p), "caption pixel");
      end
    end
    $display("caption modes done");
    wr(6'h00, 32'h10);
    for (int c = 0; c < 8; c++) begin
      wr(6'h04, 32'(c));
      wr(6'h08, 32'(c ^ 6));
      for (int f = 0; f < 3; f++) begin
        p = 11'($random(seed));
        px(p, 5'h03, 6'h05, 2'(f));
        cmp_vid(txt_exp(3'(f == 0 ? c : c ^ 6), p, 5'h03, 6'h05), "teletext pixel");
      end
    end
    $display("teletext modes done");
    p = 11'h4A7;
    wr(6'h04, 32'h2);
    for (int k = 0; k < 3; k++) begin
      px(p, rs[k], cs[k], 2'b00);
      cmp_vid(txt_exp(3'h2, p, rs[k], cs[k]), "grid edge");
    end
    $display("grid test done");
    p = 11'h5A7;
    wr(6'h04, 32'h24);
    for (int b = 0; b < 2; b++) begin
      wr(6'h0C, b == 1 ? 32'h5 : 32'h2);
      for (int k = 0; k < 3; k++) begin
        r = k == 0 ? 5'h00 : (k == 1 ? 5'h05 : 5'h18);
        px(p, r, 6'h01, 2'b00);
        cmp_vid(txt_exp(((r == 5'h05) ^ (b == 1)) ? 3'h2 : 3'h4, p, r, 6'h01), "box");
      end
    end
    $display("box test done");
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      map_w[i] = d[11:0];
      wr(6'h24, 32'(i));
      wr(6'h28, {16'h0, d[15:0]});
      wb(1'b0, 6'h28, 32'h0, q);
      cmp_val({20'h0, q[11:0]}, {20'h0, d[11:0] & 12'hBFF}, "map readback");
    end
    for (int i = 0; i < 16; i++)
      rowchk(4'(i), map_w[i], 1'b0);
    $display("map test done");
    // one area, pairs in one field, height of three rows
    wr(6'h14, 32'h43);
    wr(6'h18, 32'h29);
    wr(6'h1C, 32'h5);
    wr(6'h20, 32'h17);
    repeat (10) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    cmp_val({7'h0, scroll_live_out}, 32'h0, "scroll before sync");
    e = '{pos: 4'h4, height: 4'h3, first_row: 4'h2, last_row: 4'h9, top_line: 4'h5,
          first_scroll_row: 4'h7, enable: 1'b1};
    sync(3'b001);
    cmp_val({7'h0, scroll_live_out}, {7'h0, e}, "scroll after sync");
    rowchk(4'h4, map_w[7], 1'b1);
    rowchk(4'h6, map_w[9], 1'b1);
    rowchk(4'h7, map_w[7], 1'b0);
    rowchk(4'h3, map_w[3], 1'b0);
    wr(6'h20, 32'h7);
    sync(3'b001);
    rowchk(4'h4, map_w[4], 1'b0);
    $display("scroll test done");
    wr(6'h04, 32'h4);
    wr(6'h10, 32'h1A);
    wr(6'h00, 32'h10);
    sync(3'b010);
    repeat (16) sync(3'b100);
    px('0, 5'h03, 6'h05, 2'b00);
    cmp_vid(6'h20, "before window");
    repeat (520) @(posedge ref_clk_in);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_in);
      area_b_in <= k[0];
      px('0, 5'h03, 6'h05, 2'b00);
      cmp_vid({2'b11, 4'hA + 4'(k)}, "screen colour");
    end
    wr(6'h00, 32'h0D);
    px('0, 5'h00, 6'h00, 2'b00);
    cmp_vid(6'h3C, "caption screen colour");
    $display("screen colour test done");
    stop_test();
  end
endmodule : tb_osd_display_mode_scroll
